//--- verilog/acc_add_defs.svh
// constants for the accumulator add execution block
`ifndef ACC_ADD_DEFS_SVH
`define ACC_ADD_DEFS_SVH
// upper byte of the immediate add word: 0000 1111
`define IMM_ADD_OPC 8'h0f
// upper six bits of the file add word: 0010 01
`define FILE_ADD_OPC 6'h09
// field positions inside the instruction word
`define DEST_BIT 9
`define BANK_BIT 8
`define OPC_HI_BIT 15
`define OPC_FILE_LO_BIT 10
`define OPC_IMM_LO_BIT 8
// highest file address of the lower access bank / indexed window (95)
`define INDEX_LIMIT 8'h5f
// bank that holds the upper half of the access bank
`define ACCESS_HI_BANK 4'hf
// reset values
`define ACC_RST 8'h00
`define FLAGS_RST 5'h00
`define WORD_RST 16'h0000
`define ADDR_RST 12'h000
`define BYTE_RST 8'h00
`endif

//--- verilog/acc_add_pkg.sv
// types shared by the accumulator add execution block
package acc_add_pkg;
   // instruction quarter phases, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_Q1 = 5'b00010,
      ST_Q2 = 5'b00100,
      ST_Q3 = 5'b01000,
      ST_Q4 = 5'b10000
   } phase_t;
   // status flags produced by an add
   typedef struct packed {
      logic negative;
      logic signed_range_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } flags_t;
   // data memory port toward the file registers
   typedef struct packed {
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } file_req_t;
endpackage

//--- verilog/accumulator_add_execution.sv
// execute stage for the two accumulator add instructions
`timescale 1ns/1ps
`include "acc_add_defs.svh"

// Function
// RQ1 - immediate add: accumulator plus literal to accumulator
// RQ2 - immediate add decoded from upper byte 0x0f
// RQ3 - file add: read file, add accumulator
// RQ4 - file add decoded from 0010 01da ffff ffff
// RQ5 - destination zero: result into accumulator
// RQ6 - destination one: result written back to file
// RQ7 - bank bit zero: address in access bank
// RQ8 - bank bit one: bank select register chooses
// RQ9 - extended set: indexed offset when address <=95
// RQ10 - both adds update five status flags
// RQ11 - one word, four quarter phases per instruction
module accumulator_add_execution (
   input wire logic clk_sys_i, // core clock, 100 MHz
   input wire logic rstn_i, // asynchronous reset, active low
   input wire logic [15:0] instr_i, // instruction word
   input wire logic instr_valid_i, // instruction word offered
   output logic instr_ready_o, // block can take a word
   input wire logic ext_set_en_i, // extended instruction set enabled
   input wire logic [3:0] bank_select_register_i, // current bank number
   input wire logic [11:0] index_base_i, // base for indexed literal offset
   output acc_add_pkg::file_req_t file_req_o, // file register request
   input wire logic [7:0] file_rdata_i, // file read data, valid in Q2
   output logic [7:0] acc_o, // working register
   output acc_add_pkg::flags_t flags_o, // status flags
   output logic done_o // pulse in the write phase
);
   import acc_add_pkg::*;

   phase_t state_reg, state_next; // current quarter phase
   logic [15:0] word_reg, word_next; // word under execution
   logic imm_reg, imm_next; // decoded as immediate add
   logic file_reg, file_next; // decoded as file add
   logic [11:0] addr_reg, addr_next; // resolved file address
   logic [7:0] opnd_reg, opnd_next; // second addend
   logic [7:0] sum_reg, sum_next; // result of the add
   flags_t pend_reg, pend_next; // flags waiting for the write phase
   logic [7:0] acc_reg, acc_next; // working register
   flags_t flags_reg, flags_next; // committed flags
   logic [7:0] file_wdata_reg, file_wdata_next; // file write data
   logic [7:0] fa; // file address field
   logic [8:0] sum9; // add with carry out
   logic [4:0] sum5; // low nibble add for half carry
   logic take; // new word accepted

   assign fa = word_reg[7:0];
   // a word is taken when idle or while the previous one writes back
   assign instr_ready_o = (state_reg == ST_IDLE) || (state_reg == ST_Q4);
   assign take = instr_valid_i && instr_ready_o;
   assign sum9 = {1'b0, acc_reg} + {1'b0, opnd_reg};
   assign sum5 = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]};

   // next values for phase, decode, address and arithmetic
   always_comb begin
      state_next = state_reg;
      word_next = word_reg;
      imm_next = imm_reg;
      file_next = file_reg;
      addr_next = addr_reg;
      opnd_next = opnd_reg;
      sum_next = sum_reg;
      pend_next = pend_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      file_wdata_next = file_wdata_reg;
      case (state_reg)
         ST_IDLE: begin
            // wait for a word
            if (take) begin
               word_next = instr_i;
               state_next = ST_Q1;
            end
         end
         ST_Q1: begin
            // decode and resolve the file address [RQ11]
            imm_next = (word_reg[`OPC_HI_BIT:`OPC_IMM_LO_BIT] == `IMM_ADD_OPC); // [RQ2]
            file_next = (word_reg[`OPC_HI_BIT:`OPC_FILE_LO_BIT] == `FILE_ADD_OPC); // [RQ4]
            if (word_reg[`BANK_BIT]) begin
               // bank chosen by the bank select register [RQ8]
               addr_next = {bank_select_register_i, fa};
            end else if (ext_set_en_i && (fa <= `INDEX_LIMIT)) begin
               // indexed literal offset [RQ9]
               addr_next = index_base_i + {4'h0, fa};
            end else if (fa <= `INDEX_LIMIT) begin
               // lower half of the access bank [RQ7]
               addr_next = {4'h0, fa};
            end else begin
               // upper half of the access bank [RQ7]
               addr_next = {`ACCESS_HI_BANK, fa};
            end
            state_next = ST_Q2;
         end
         ST_Q2: begin
            // fetch the second addend: literal or file register
            if (imm_reg) begin
               opnd_next = fa; // [RQ1]
            end else begin
               opnd_next = file_rdata_i; // [RQ3]
            end
            state_next = ST_Q3;
         end
         ST_Q3: begin
            // add and form the flags [RQ10]
            sum_next = sum9[7:0];
            pend_next.carry = sum9[8];
            pend_next.half_carry_flag = sum5[4];
            pend_next.zero = (sum9[7:0] == `BYTE_RST);
            pend_next.negative = sum9[7];
            pend_next.signed_range_flag = (acc_reg[7] == opnd_reg[7]) && (sum9[7] != acc_reg[7]);
            state_next = ST_Q4;
         end
         ST_Q4: begin
            // write to destination and commit flags
            if (imm_reg || file_reg) begin
               flags_next = pend_reg; // [RQ10]
            end
            if (imm_reg) begin
               acc_next = sum_reg; // [RQ1]
            end else if (file_reg && !word_reg[`DEST_BIT]) begin
               acc_next = sum_reg; // [RQ5]
            end
            if (take) begin
               word_next = instr_i;
               state_next = ST_Q1;
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // file write data prepared in Q3 so it is a flop in Q4
      if (state_reg == ST_Q3) begin
         file_wdata_next = sum9[7:0];
      end
   end

   // state registers
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= ST_IDLE;
         word_reg <= `WORD_RST;
         imm_reg <= 1'b0;
         file_reg <= 1'b0;
         addr_reg <= `ADDR_RST;
         opnd_reg <= `BYTE_RST;
         sum_reg <= `BYTE_RST;
         pend_reg <= `FLAGS_RST;
         acc_reg <= `ACC_RST;
         flags_reg <= `FLAGS_RST;
         file_wdata_reg <= `BYTE_RST;
      end else begin
         state_reg <= state_next;
         word_reg <= word_next;
         imm_reg <= imm_next;
         file_reg <= file_next;
         addr_reg <= addr_next;
         opnd_reg <= opnd_next;
         sum_reg <= sum_next;
         pend_reg <= pend_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         file_wdata_reg <= file_wdata_next;
      end
   end

   // file port: read in Q2, write back in Q4 when destination is the file
   always_comb begin
      file_req_o.addr = addr_reg;
      file_req_o.rd = (state_reg == ST_Q2) && file_reg; // [RQ3]
      file_req_o.wr = (state_reg == ST_Q4) && file_reg && word_reg[`DEST_BIT]; // [RQ6]
      file_req_o.wdata = file_wdata_reg;
   end

   assign acc_o = acc_reg;
   assign flags_o = flags_reg;
   assign done_o = (state_reg == ST_Q4);

   // phases run Q1 to Q4 without gaps
   property p_phases;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1) |=> (state_reg == ST_Q2) ##1 (state_reg == ST_Q3) ##1 done_o;
   endproperty
   a_phases: assert property (p_phases) else $error("quarter phases out of order"); // [RQ11]

   // immediate add result lands in the accumulator
   property p_imm_sum;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (done_o && imm_reg) |=> (acc_o == 8'($past(acc_o) + $past(word_reg[7:0])));
   endproperty
   a_imm_sum: assert property (p_imm_sum) else $error("immediate sum wrong"); // [RQ1]

   // immediate opcode decodes as immediate add
   property p_imm_dec;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1 && word_reg[15:8] == 8'h0f) |=> imm_reg && !file_reg;
   endproperty
   a_imm_dec: assert property (p_imm_dec) else $error("immediate decode wrong"); // [RQ2]

   // file add reads in Q2 and a file opcode decodes as file add
   property p_file_rd;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1 && word_reg[15:10] == 6'h09) |=> file_req_o.rd;
   endproperty
   a_file_rd: assert property (p_file_rd) else $error("file add did not read"); // [RQ4]

   // file write carries the accumulator plus the data read
   property p_file_sum;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      file_req_o.rd ##2 file_req_o.wr |->
         file_req_o.wdata == 8'($past(file_rdata_i, 2) + acc_o);
   endproperty
   a_file_sum: assert property (p_file_sum) else $error("file write data wrong"); // [RQ3]

   // destination zero never writes the file
   property p_dest_w;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (done_o && file_reg && !word_reg[9]) |-> !file_req_o.wr ##1 (acc_o == $past(sum_reg));
   endproperty
   a_dest_w: assert property (p_dest_w) else $error("destination zero misrouted"); // [RQ5]

   // destination one writes the file and keeps the accumulator
   property p_dest_f;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (done_o && file_reg && word_reg[9]) |-> file_req_o.wr ##1 $stable(acc_o);
   endproperty
   a_dest_f: assert property (p_dest_f) else $error("destination one misrouted"); // [RQ6]

   // bank bit one takes the bank from the bank select register
   property p_bank;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1 && word_reg[8]) |=>
         file_req_o.addr == {$past(bank_select_register_i), $past(word_reg[7:0])};
   endproperty
   a_bank: assert property (p_bank) else $error("banked address wrong"); // [RQ8]

   // access bank without extended set splits at the indexed limit
   property p_access;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1 && !word_reg[8] && !ext_set_en_i) |=>
         file_req_o.addr[11:8] == (($past(word_reg[7:0]) > 8'h5f) ? 4'hf : 4'h0);
   endproperty
   a_access: assert property (p_access) else $error("access bank address wrong"); // [RQ7]

   // indexed literal offset adds the base
   property p_index;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (state_reg == ST_Q1 && !word_reg[8] && ext_set_en_i && word_reg[7:0] <= 8'h5f) |=>
         file_req_o.addr == 12'($past(index_base_i) + {4'h0, $past(word_reg[7:0])});
   endproperty
   a_index: assert property (p_index) else $error("indexed address wrong"); // [RQ9]

   // zero and negative follow the result
   property p_flags;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (done_o && (imm_reg || file_reg)) |=>
         flags_o.zero == ($past(sum_reg) == 8'h00) && flags_o.negative == $past(sum_reg[7]);
   endproperty
   a_flags: assert property (p_flags) else $error("flags wrong"); // [RQ10]

   c_imm: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) done_o && imm_reg);
   c_file_wr: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) file_req_o.wr);
   c_index: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      done_o && file_reg && ext_set_en_i && !word_reg[8]);
   c_ovf: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) flags_o.signed_range_flag);
endmodule

//--- testbench/tb.sv
// self-checking bench for the accumulator add execution block
`timescale 1ns/1ps
module tb;
   import acc_add_pkg::*;
   logic clk_sys_i = 1'b0; // core clock
   logic rstn_i = 1'b0; // reset, active low
   logic [15:0] instr_i = 16'h0000; // offered word
   logic instr_valid_i = 1'b0; // word offered
   logic ext_set_en_i = 1'b0; // extended set enable
   logic [3:0] bank_select_register_i = 4'h0; // bank number
   logic [11:0] index_base_i = 12'h000; // indexed base
   logic [7:0] file_rdata_i = 8'h00; // file read data
   logic instr_ready_o;
   file_req_t file_req_o;
   logic [7:0] acc_o;
   flags_t flags_o;
   logic done_o;
   int miscompares = 0;
   int cmp_count = 0;
   logic [7:0] acc_m = 8'h00; // expected working register
   flags_t flg_m = 5'h00; // expected flags
   logic [3:0] rd_s, wr_s, dn_s, rdy_s; // per-phase samples, bit 0 is q1
   logic [11:0] addr_s; // address seen in q2
   logic [7:0] wd_s; // write data seen in q4

   accumulator_add_execution accumulator_add_execution_inst (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .instr_i(instr_i),
      .instr_valid_i(instr_valid_i),
      .instr_ready_o(instr_ready_o),
      .ext_set_en_i(ext_set_en_i),
      .bank_select_register_i(bank_select_register_i),
      .index_base_i(index_base_i),
      .file_req_o(file_req_o),
      .file_rdata_i(file_rdata_i),
      .acc_o(acc_o),
      .flags_o(flags_o),
      .done_o(done_o)
   );

   // free-running 100 MHz clock
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flags(input flags_t got, input flags_t exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t flags got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_seq(input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t phases got %h exp %h", $time, got, exp);
      end
   endtask

   // reference sum; also sets the expected flags
   function automatic logic [7:0] add_m(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      flg_m = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
               ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
      return s[7:0];
   endfunction

   // offer one word, sample q1..q4, return in the cycle after q4
   task automatic run(input logic [15:0] w, input logic [7:0] rv);
      @(negedge clk_sys_i);
      instr_i = w;
      instr_valid_i = 1'b1;
      file_rdata_i = ~rv;
      @(negedge clk_sys_i);
      instr_valid_i = 1'b0;
      for (int k = 0; k < 4; k++) begin
         if (k > 0) @(negedge clk_sys_i);
         // data only valid while the read strobe stands
         file_rdata_i = (k == 1) ? rv : ~rv;
         rd_s[k] = file_req_o.rd;
         wr_s[k] = file_req_o.wr;
         dn_s[k] = done_o;
         rdy_s[k] = instr_ready_o;
         if (k == 1) addr_s = file_req_o.addr;
         if (k == 3) wd_s = file_req_o.wdata;
      end
      @(negedge clk_sys_i);
   endtask

   task automatic do_imm(input logic [7:0] k);
      acc_m = add_m(acc_m, k);
      run({8'h0f, k}, 8'h00);
      cmp_seq(dn_s, 4'b1000);
      cmp_seq(rdy_s, 4'b1000);
      cmp_seq(rd_s | wr_s, 4'b0000);
      cmp_val({4'h0, acc_o}, {4'h0, acc_m});
      cmp_flags(flags_o, flg_m);
   endtask

   task automatic do_file(input logic [15:0] w, input logic [7:0] rv, input logic [11:0] ea);
      logic [7:0] s;
      s = add_m(acc_m, rv);
      run(w, rv);
      cmp_seq(rd_s, 4'b0010);
      cmp_seq(wr_s, {w[9], 3'b000});
      cmp_seq(dn_s, 4'b1000);
      cmp_val(addr_s, ea);
      if (w[9]) cmp_val({4'h0, wd_s}, {4'h0, s});
      else acc_m = s;
      cmp_val({4'h0, acc_o}, {4'h0, acc_m});
      cmp_flags(flags_o, flg_m);
   endtask

   // reset values of the outputs
   task automatic t_reset;
      cmp_val({4'h0, acc_o}, 12'h000);
      cmp_flags(flags_o, 5'h00);
      cmp_seq({instr_ready_o, done_o, file_req_o.rd, file_req_o.wr}, 4'b1000);
   endtask

   // literal adds: plain, carry to zero, signed overflow, largest literal
   task automatic t_imm;
      do_imm(8'h10);
      do_imm(8'h15);
      do_imm(8'hdb);
      do_imm(8'h7f);
      do_imm(8'h01);
      do_imm(8'hff);
   endtask

   // file adds over all four d/a combinations
   task automatic t_file;
      bank_select_register_i = 4'h5;
      do_file(16'h2440, 8'hc2, 12'h040);
      do_file(16'h2780, 8'h33, 12'h580);
      bank_select_register_i = 4'ha;
      do_file(16'h2580, 8'h5a, 12'ha80);
      do_file(16'h26ff, 8'h01, 12'hfff);
   endtask

   // indexed offset window edges, wrap, and bank mode unaffected
   task automatic t_index;
      ext_set_en_i = 1'b1;
      index_base_i = 12'h3a0;
      do_file(16'h245f, 8'h21, 12'h3ff);
      do_file(16'h2460, 8'h80, 12'hf60);
      index_base_i = 12'hfff;
      do_file(16'h2601, 8'h7e, 12'h000);
      bank_select_register_i = 4'h3;
      do_file(16'h2510, 8'h44, 12'h310);
      ext_set_en_i = 1'b0;
      do_file(16'h245f, 8'h09, 12'h05f);
   endtask

   // foreign words: four phases, nothing changes
   task automatic t_unknown;
      logic [15:0] w [3];
      w = '{16'h0b12, 16'h2840, 16'h2340};
      foreach (w[i]) begin
         run(w[i], 8'h99);
         cmp_seq(rd_s | wr_s, 4'b0000);
         cmp_seq(dn_s, 4'b1000);
         cmp_val({4'h0, acc_o}, {4'h0, acc_m});
         cmp_flags(flags_o, flg_m);
      end
   endtask

   // back to back: second word waits, then is taken in q4 of the first
   task automatic t_b2b;
      logic [7:0] s;
      acc_m = add_m(acc_m, 8'h21);
      s = add_m(acc_m, 8'h6f);
      @(negedge clk_sys_i);
      instr_i = 16'h0f21;
      instr_valid_i = 1'b1;
      @(negedge clk_sys_i);
      // next word offered at once; ready stays low through q1..q3
      instr_i = 16'h0f6f;
      repeat (3) begin
         cmp_seq({done_o, instr_ready_o, 2'b00}, 4'b0000);
         @(negedge clk_sys_i);
      end
      cmp_seq({done_o, instr_ready_o, 2'b00}, 4'b1100);
      @(negedge clk_sys_i);
      instr_valid_i = 1'b0;
      // second word went straight to q1, first sum already written
      cmp_seq({done_o, instr_ready_o, 2'b00}, 4'b0000);
      cmp_val({4'h0, acc_o}, {4'h0, acc_m});
      repeat (3) @(negedge clk_sys_i);
      cmp_seq({done_o, instr_ready_o, 2'b00}, 4'b1100);
      @(negedge clk_sys_i);
      acc_m = s;
      cmp_val({4'h0, acc_o}, {4'h0, acc_m});
      cmp_flags(flags_o, flg_m);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (8) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      @(negedge clk_sys_i);
      t_reset();
      t_imm();
      t_file();
      t_index();
      t_unknown();
      t_b2b();
      tally_and_finish();
   end

   // watchdog, far beyond the roughly 130 clock cycles used
   initial begin
      #50000;
      miscompares++;
      tally_and_finish();
   end
endmodule
